/* pkg/ptdc_map.svh */
/*
 * Register offsets, reset values, write masks, field positions and timing
 * counts of the PHY timing and DSP configuration register bank.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef PTDC_MAP_SVH
`define PTDC_MAP_SVH

// register offsets on the management port
`define PTDC_OFS_PTP_CFG      9'h03F
`define PTDC_OFS_FEF_CTL      9'h040
`define PTDC_OFS_TXC_PHASE    9'h042
`define PTDC_OFS_DSP_CFG1     9'h101
`define PTDC_OFS_DFILT_CFG1   9'h106
`define PTDC_OFS_DFILT_CFG2   9'h107
`define PTDC_OFS_DSP_CFG2     9'h10F
`define PTDC_OFS_DSP_CFG3     9'h111

// reset values
`define PTDC_RST_PTP_CFG      16'hB4FF
`define PTDC_RST_FEF_CTL      16'hC11D
`define PTDC_RST_TXC_PHASE    16'h0000
`define PTDC_RST_DSP_CFG1     16'h2000
`define PTDC_RST_DFILT_CFG1   16'hB0BB
`define PTDC_RST_DFILT_CFG2   16'h0605
`define PTDC_RST_DSP_CFG2     16'h0300
`define PTDC_RST_DSP_CFG3     16'h6003

// writable bits; others read back their fixed default
`define PTDC_WM_TXC_PHASE     16'h001F
`define PTDC_WM_DSP_CFG1      16'hFF80
`define PTDC_WM_DFILT_CFG1    16'hF7FF

// field positions
`define PTDC_F_TX_TIMING      15:13
`define PTDC_F_RX_TIMING      12:10
`define PTDC_F_TXERR_SEL      9:8
`define PTDC_F_UNLOCK_TIMER   7:4
`define PTDC_B_FEF_GEN_DIS    6
`define PTDC_B_FEF_DET_DIS    5
`define PTDC_B_PHASE_EN       4
`define PTDC_F_PHASE_VAL      3:0
`define PTDC_B_FILT_DIS       7
`define PTDC_F_THR_SET1       15:12
`define PTDC_B_COEF_EN        10
`define PTDC_F_LONG_COEF      7:6
`define PTDC_F_THR_SET0       3:0
`define PTDC_B_LOOP_INPUT     8
`define PTDC_F_START_GAIN     3:0

// timing: sfd delay step and clock period, both in ps
`define PTDC_SFD_STEP_PS      32'd8000
`define PTDC_MCLK_PERIOD_PS   32'd25000
// gap count loaded after each 4 ns phase step of the transmit clock; 5 idle cycles lie between steps
`define PTDC_PHASE_GAP_CYC    4'h4

`endif

/* pkg/ptdc_pkg.sv */
/*
 * Types of the PHY timing and DSP configuration register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package ptdc_pkg;

    // transmit-error input source
    typedef enum logic [1:0] {
        PTDC_TXERR_NONE = 2'h0,
        PTDC_TXERR_RSVD = 2'h1,
        PTDC_TXERR_INT  = 2'h2,
        PTDC_TXERR_COL  = 2'h3
    } ptdc_txerr_sel_t;

    // transmit sfd pulse pin choice
    typedef enum logic [2:0] {
        PTDC_PIN_LED  = 3'h3,
        PTDC_PIN_CRS  = 3'h4,
        PTDC_PIN_COL  = 3'h5,
        PTDC_PIN_INT  = 3'h6,
        PTDC_PIN_NONE = 3'h7
    } ptdc_pin_sel_t;

    // phase stepper states
    typedef enum logic [1:0] {
        PTDC_PH_IDLE = 2'h0,
        PTDC_PH_STEP = 2'h1,
        PTDC_PH_GAP  = 2'h2
    } ptdc_phase_state_t;

endpackage : ptdc_pkg

`default_nettype wire

/* hw/ptdc_phase_step.sv */
/*
 * Transmit clock phase stepper: walks the present phase toward a target
 * one 4 ns unit at a time, pulsing a step request to the clock generator.
 * Assumes start is a one-cycle pulse on mclk and the target is stable
 * from that pulse on.
 */
`include "ptdc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ptdc_phase_step (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // control
    input  wire logic       start,
    input  wire logic [3:0] target,
    // state
    output logic      [3:0] phase_q,
    output logic            busy,
    // clock generator side
    output logic            step_q,
    output logic            step_late_q
);

    ptdc_pkg::ptdc_phase_state_t state_q;
    logic [3:0]                  gap_q;
    logic [3:0]                  target_q;

    assign busy = (state_q != ptdc_pkg::PTDC_PH_IDLE);

    // one unit per step keeps the transmit clock free of glitches
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q     <= ptdc_pkg::PTDC_PH_IDLE;
            phase_q     <= 4'h0;
            target_q    <= 4'h0;
            gap_q       <= 4'h0;
            step_q      <= 1'b0;
            step_late_q <= 1'b0;
        end else begin
            step_q <= 1'b0;
            case (state_q)
                ptdc_pkg::PTDC_PH_IDLE: begin
                    if (start && target != phase_q) begin
                        target_q <= target;
                        state_q  <= ptdc_pkg::PTDC_PH_STEP;
                    end
                end
                ptdc_pkg::PTDC_PH_STEP: begin
                    step_q      <= 1'b1;
                    step_late_q <= (target_q > phase_q);
                    phase_q     <= (target_q > phase_q) ? phase_q + 4'h1 : phase_q - 4'h1;
                    gap_q       <= `PTDC_PHASE_GAP_CYC;
                    state_q     <= ptdc_pkg::PTDC_PH_GAP;
                end
                ptdc_pkg::PTDC_PH_GAP: begin
                    if (gap_q != 4'h0) begin
                        gap_q <= gap_q - 4'h1;
                    end else if (target_q != phase_q) begin
                        state_q <= ptdc_pkg::PTDC_PH_STEP;
                    end else begin
                        state_q <= ptdc_pkg::PTDC_PH_IDLE;
                    end
                end
                default: begin
                    state_q <= ptdc_pkg::PTDC_PH_IDLE;
                end
            endcase
        end
    end

endmodule : ptdc_phase_step

`default_nettype wire

/* hw/ptdc_regs.sv */
/*
 * PHY timing and DSP configuration register bank with sfd delay,
 * pin routing, tx error select, fault gating and phase stepping.
 * Assumes a master on mclk with one-cycle strobes, read data in
 * the cycle after the read strobe, and asynchronous pin inputs.
 */
// Function
// - tx sfd delay in 8 ns steps, bits 15:13, reset 101.
// - rx sfd delay in 8 ns steps, bits 12:10, reset 101.
// - tx error: 00 none, 10 int pin, 11 col pin, 01 reserved.
// - unlock link-down timer, bits 7:4, reset 1111.
// - bit 6 stops far-end-fault generation.
// - bit 5 stops far-end-fault detection.
// - self-clearing bit 4 starts a phase step.
// - phase reads present value; 4 ns per unit of change.
// - bit 7 disables filter during training.
// - bits 15:12, reset 1011, gate coefficient set 1.
// - bits 3:0, reset 1011, gate coefficient set 0.
// - bit 10 enables filter coefficient in steady state.
// - bits 7:6, reset 10, long-cable coefficients.
// - bit 8, reset 1, selects gain loop input.
// - start gain index loaded as training begins.
// - tx sfd pin: 011 led, 100 crs, 101 col, 110 int, 111 none.
`include "ptdc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ptdc_regs (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // management port
    input  wire logic [8:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata_q,
    // sfd indications from the datapath
    input  wire logic        tx_sfd_in,
    input  wire logic        rx_sfd_in,
    input  wire logic [2:0]  sfd_pulse_pin_select,
    output logic             tx_sfd_dly_q,
    output logic             rx_sfd_dly_q,
    // sfd pulse pin outputs
    output logic             first_led_pin_sfd_q,
    output logic             crs_pin_sfd_q,
    output logic             col_pin_sfd_q,
    output logic             interrupt_powerdown_pin_sfd_q,
    // transmit error inputs (pins)
    input  wire logic        interrupt_powerdown_pin_in,
    input  wire logic        col_pin_in,
    output logic             tx_err_q,
    // link-down timer
    output logic      [3:0]  unlock_timer_q,
    // far end fault
    input  wire logic        far_end_fault_req,
    input  wire logic        far_end_fault_rx,
    output logic             far_end_fault_gen_q,
    output logic             far_end_fault_det_q,
    // transmit clock phase
    output logic             txc_step_q,
    output logic             txc_step_late_q,
    output logic             txc_phase_busy,
    // filter and gain loop
    input  wire logic [3:0]  cable_metric,
    input  wire logic        gain_train_start,
    output logic             filter_dis_q,
    output logic             coef_set1_act_q,
    output logic             coef_set0_act_q,
    output logic             coef_en_q,
    output logic      [1:0]  long_coef_q,
    output logic             loop_input_sel_q,
    output logic      [3:0]  gain_index_q
);

    // register storage
    logic [15:0] ptp_timing_config_q;
    logic [15:0] fiber_far_end_fault_control_q;
    logic [15:0] dsp_config_one_q;
    logic [15:0] digital_filter_config_one_q;
    logic [15:0] digital_filter_config_two_q;
    logic [15:0] dsp_config_two_q;
    logic [15:0] dsp_config_three_q;
    logic        phase_en_q;
    logic [3:0]  phase_target_q;
    logic [3:0]  phase_now;
    logic [15:0] rdata_d;

    // synchronisers and delay lines
    logic [1:0]  int_sync_q;
    logic [1:0]  col_sync_q;
    logic [3:0]  tx_line_q;
    logic [3:0]  rx_line_q;

    // write strobe decode
    function automatic logic hit(input logic [8:0] ofs);
        hit = wr && (addr == ofs);
    endfunction : hit

    // masked write keeps read-only bits at their fixed defaults
    function automatic logic [15:0] mwr(input logic [15:0] old, input logic [15:0] wm);
        mwr = (wdata & wm) | (old & ~wm);
    endfunction : mwr

    // 8 ns steps rounded up to whole mclk cycles
    function automatic logic [1:0] dly_cyc(input logic [2:0] steps);
        logic [31:0] ps;
        ps      = 32'(steps) * `PTDC_SFD_STEP_PS;
        dly_cyc = 2'((ps + `PTDC_MCLK_PERIOD_PS - 32'd1) / `PTDC_MCLK_PERIOD_PS);
    endfunction : dly_cyc

    // timing and error selection register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ptp_timing_config_q <= `PTDC_RST_PTP_CFG;
        end else if (hit(`PTDC_OFS_PTP_CFG)) begin
            ptp_timing_config_q <= wdata;
        end
    end

    // fiber far-end fault control
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fiber_far_end_fault_control_q <= `PTDC_RST_FEF_CTL;
        end else if (hit(`PTDC_OFS_FEF_CTL)) begin
            fiber_far_end_fault_control_q <= wdata;
        end
    end

    // dsp and filter configuration
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            dsp_config_one_q            <= `PTDC_RST_DSP_CFG1;
            digital_filter_config_one_q <= `PTDC_RST_DFILT_CFG1;
            digital_filter_config_two_q <= `PTDC_RST_DFILT_CFG2;
            dsp_config_two_q            <= `PTDC_RST_DSP_CFG2;
            dsp_config_three_q          <= `PTDC_RST_DSP_CFG3;
        end else begin
            if (hit(`PTDC_OFS_DSP_CFG1)) begin
                dsp_config_one_q <= mwr(dsp_config_one_q, `PTDC_WM_DSP_CFG1);
            end
            if (hit(`PTDC_OFS_DFILT_CFG1)) begin
                digital_filter_config_one_q <= mwr(digital_filter_config_one_q,
                                                   `PTDC_WM_DFILT_CFG1);
            end
            if (hit(`PTDC_OFS_DFILT_CFG2)) begin
                digital_filter_config_two_q <= wdata;
            end
            if (hit(`PTDC_OFS_DSP_CFG2)) begin
                dsp_config_two_q <= wdata;
            end
            if (hit(`PTDC_OFS_DSP_CFG3)) begin
                dsp_config_three_q <= wdata;
            end
        end
    end

    // phase target and self-clearing enable; enable lasts one cycle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            phase_target_q <= 4'h0;
            phase_en_q     <= 1'b0;
        end else if (hit(`PTDC_OFS_TXC_PHASE)) begin
            phase_target_q <= wdata[`PTDC_F_PHASE_VAL];
            phase_en_q     <= wdata[`PTDC_B_PHASE_EN];
        end else begin
            phase_en_q <= 1'b0;
        end
    end

    // phase stepper walks toward the target written with the enable
    ptdc_phase_step u_phase (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .start       (phase_en_q),
        .target      (phase_target_q),
        .phase_q     (phase_now),
        .busy        (txc_phase_busy),
        .step_q      (txc_step_q),
        .step_late_q (txc_step_late_q)
    );

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 16'h0000;
        case (addr)
            `PTDC_OFS_PTP_CFG:    rdata_d = ptp_timing_config_q;
            `PTDC_OFS_FEF_CTL:    rdata_d = fiber_far_end_fault_control_q;
            `PTDC_OFS_TXC_PHASE:  rdata_d = {11'h000, phase_en_q, phase_now};
            `PTDC_OFS_DSP_CFG1:   rdata_d = dsp_config_one_q;
            `PTDC_OFS_DFILT_CFG1: rdata_d = digital_filter_config_one_q;
            `PTDC_OFS_DFILT_CFG2: rdata_d = digital_filter_config_two_q;
            `PTDC_OFS_DSP_CFG2:   rdata_d = dsp_config_two_q;
            `PTDC_OFS_DSP_CFG3:   rdata_d = dsp_config_three_q;
            default:              rdata_d = 16'h0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rd ? rdata_d : 16'h0000;
        end
    end

    // sfd delay lines, tap chosen by the programmed step count
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_line_q    <= 4'h0;
            rx_line_q    <= 4'h0;
            tx_sfd_dly_q <= 1'b0;
            rx_sfd_dly_q <= 1'b0;
        end else begin
            tx_line_q    <= {tx_line_q[2:0], tx_sfd_in};
            rx_line_q    <= {rx_line_q[2:0], rx_sfd_in};
            tx_sfd_dly_q <= tx_line_q[dly_cyc(ptp_timing_config_q[`PTDC_F_TX_TIMING])];
            rx_sfd_dly_q <= rx_line_q[dly_cyc(ptp_timing_config_q[`PTDC_F_RX_TIMING])];
        end
    end

    // tx sfd pulse pin routing; reserved codes drive no pin
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            first_led_pin_sfd_q           <= 1'b0;
            crs_pin_sfd_q                 <= 1'b0;
            col_pin_sfd_q                 <= 1'b0;
            interrupt_powerdown_pin_sfd_q <= 1'b0;
        end else begin
            first_led_pin_sfd_q           <= tx_line_q[dly_cyc(ptp_timing_config_q[`PTDC_F_TX_TIMING])]
                && (sfd_pulse_pin_select == ptdc_pkg::PTDC_PIN_LED);
            crs_pin_sfd_q                 <= tx_line_q[dly_cyc(ptp_timing_config_q[`PTDC_F_TX_TIMING])]
                && (sfd_pulse_pin_select == ptdc_pkg::PTDC_PIN_CRS);
            col_pin_sfd_q                 <= tx_line_q[dly_cyc(ptp_timing_config_q[`PTDC_F_TX_TIMING])]
                && (sfd_pulse_pin_select == ptdc_pkg::PTDC_PIN_COL);
            interrupt_powerdown_pin_sfd_q <= tx_line_q[dly_cyc(ptp_timing_config_q[`PTDC_F_TX_TIMING])]
                && (sfd_pulse_pin_select == ptdc_pkg::PTDC_PIN_INT);
        end
    end

    // pin synchronisers; only the second stage is read
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            int_sync_q <= 2'h0;
            col_sync_q <= 2'h0;
        end else begin
            int_sync_q <= {int_sync_q[0], interrupt_powerdown_pin_in};
            col_sync_q <= {col_sync_q[0], col_pin_in};
        end
    end

    // transmit error source; reserved code behaves as none
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_err_q <= 1'b0;
        end else begin
            case (ptdc_pkg::ptdc_txerr_sel_t'(ptp_timing_config_q[`PTDC_F_TXERR_SEL]))
                ptdc_pkg::PTDC_TXERR_INT: tx_err_q <= int_sync_q[1];
                ptdc_pkg::PTDC_TXERR_COL: tx_err_q <= col_sync_q[1];
                default:                  tx_err_q <= 1'b0;
            endcase
        end
    end

    // far-end fault gating and link-down timer
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            far_end_fault_gen_q <= 1'b0;
            far_end_fault_det_q <= 1'b0;
            unlock_timer_q      <= 4'hF;
        end else begin
            far_end_fault_gen_q <= far_end_fault_req
                && !fiber_far_end_fault_control_q[`PTDC_B_FEF_GEN_DIS];
            far_end_fault_det_q <= far_end_fault_rx
                && !fiber_far_end_fault_control_q[`PTDC_B_FEF_DET_DIS];
            unlock_timer_q      <= ptp_timing_config_q[`PTDC_F_UNLOCK_TIMER];
        end
    end

    // filter settings and coefficient set decision
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            filter_dis_q     <= 1'b0;
            coef_set1_act_q  <= 1'b0;
            coef_set0_act_q  <= 1'b0;
            coef_en_q        <= 1'b0;
            long_coef_q      <= 2'h2;
            loop_input_sel_q <= 1'b1;
        end else begin
            filter_dis_q     <= dsp_config_one_q[`PTDC_B_FILT_DIS];
            coef_set1_act_q  <= (cable_metric
                >= digital_filter_config_one_q[`PTDC_F_THR_SET1]);
            coef_set0_act_q  <= (cable_metric
                >= digital_filter_config_one_q[`PTDC_F_THR_SET0]);
            coef_en_q        <= digital_filter_config_one_q[`PTDC_B_COEF_EN];
            long_coef_q      <= digital_filter_config_one_q[`PTDC_F_LONG_COEF];
            loop_input_sel_q <= dsp_config_two_q[`PTDC_B_LOOP_INPUT];
        end
    end

    // gain index seeded at the start of gain training
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            gain_index_q <= 4'h3;
        end else if (gain_train_start) begin
            gain_index_q <= dsp_config_three_q[`PTDC_F_START_GAIN];
        end
    end

endmodule : ptdc_regs

`default_nettype wire

/* verification/ptdc_regs_assertions.sv */
/*
 * Port checker of the timing and dsp configuration register bank.
 * Assumes the map header and a bind onto ptdc_regs below.
 */
`include "ptdc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ptdc_regs_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // management port
    input wire logic [8:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata_q,
    // fault and phase
    input wire logic        far_end_fault_req,
    input wire logic        far_end_fault_rx,
    input wire logic        far_end_fault_gen_q,
    input wire logic        far_end_fault_det_q,
    input wire logic        txc_step_q,
    input wire logic        txc_phase_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // bus steps used by several properties
    sequence s_set_ph; wr && addr == `PTDC_OFS_TXC_PHASE && wdata[4]; endsequence
    sequence s_rd_ph; rd && addr == `PTDC_OFS_TXC_PHASE; endsequence
    sequence s_wr2; wr && addr == `PTDC_OFS_DFILT_CFG2; endsequence
    sequence s_rd2; rd && addr == `PTDC_OFS_DFILT_CFG2; endsequence

    property p_rd_idle; !$past(rd) |-> rdata_q == 16'h0000; endproperty
    property p_unmapped;
        rd && !(addr inside {`PTDC_OFS_PTP_CFG, `PTDC_OFS_FEF_CTL, `PTDC_OFS_TXC_PHASE,
            `PTDC_OFS_DSP_CFG1, `PTDC_OFS_DFILT_CFG1, `PTDC_OFS_DFILT_CFG2,
            `PTDC_OFS_DSP_CFG2, `PTDC_OFS_DSP_CFG3}) |=> rdata_q == 16'h0000;
    endproperty
    property p_ro_phase; s_rd_ph |=> rdata_q[15:5] == 11'h000; endproperty
    property p_rw_back; s_wr2 ##1 s_rd2 |=> rdata_q == $past(wdata, 2); endproperty
    property p_fef_gen; far_end_fault_gen_q |-> $past(far_end_fault_req); endproperty
    property p_fef_det; far_end_fault_det_q |-> $past(far_end_fault_rx); endproperty
    property p_en_read; s_set_ph ##1 s_rd_ph |=> rdata_q[4]; endproperty
    property p_step_busy; txc_step_q |-> $past(txc_phase_busy); endproperty
    property p_step_gap; txc_step_q |=> !txc_step_q [*5]; endproperty
    property p_busy_end; $rose(txc_phase_busy) |-> ##[1:100] !txc_phase_busy; endproperty

    a_rd_idle:   assert property (p_rd_idle) else $error("read data outside slot");
    a_unmapped:  assert property (p_unmapped) else $error("unmapped read not zero");
    a_ro_phase:  assert property (p_ro_phase) else $error("phase upper bits set");
    a_rw_back:   assert property (p_rw_back) else $error("readback differs");
    a_fef_gen:   assert property (p_fef_gen) else $error("fault gen uncaused");
    a_fef_det:   assert property (p_fef_det) else $error("fault det uncaused");
    a_en_read:   assert property (p_en_read) else $error("enable not seen");
    a_step_busy: assert property (p_step_busy) else $error("step while idle");
    a_step_gap:  assert property (p_step_gap) else $error("steps too close");
    a_busy_end:  assert property (p_busy_end) else $error("stepper hung");
endmodule : ptdc_regs_checker

bind ptdc_regs ptdc_regs_checker chk_u (.*);

`default_nettype wire

/* verification/test_ptdc_regs.sv */
/*
 * Self-checking bench of the timing and dsp configuration register bank.
 * Assumes ptdc_regs, the map header and the bound checker.
 */
`include "ptdc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module test_ptdc_regs;
    logic        mclk, rst_b, wr, rd, tx_sfd_in, rx_sfd_in, gain_train_start, rd_d;
    logic        interrupt_powerdown_pin_in, col_pin_in, far_end_fault_req, far_end_fault_rx;
    logic [8:0]  addr;
    logic [15:0] wdata, rdata_q;
    logic [2:0]  sfd_pulse_pin_select;
    logic [3:0]  cable_metric, unlock_timer_q, gain_index_q;
    logic [1:0]  long_coef_q;
    logic        tx_sfd_dly_q, rx_sfd_dly_q, first_led_pin_sfd_q, crs_pin_sfd_q, col_pin_sfd_q;
    logic        interrupt_powerdown_pin_sfd_q, tx_err_q, far_end_fault_gen_q;
    logic        far_end_fault_det_q, txc_step_q, txc_step_late_q, txc_phase_busy;
    logic        filter_dis_q, coef_set1_act_q, coef_set0_act_q, coef_en_q, loop_input_sel_q;
    int          bad_count, n_compared;
    logic [15:0] exp_q[$];
    logic [15:0] w[8];
    localparam logic [8:0]  OFS[8] = '{`PTDC_OFS_PTP_CFG, `PTDC_OFS_FEF_CTL,
        `PTDC_OFS_TXC_PHASE, `PTDC_OFS_DSP_CFG1, `PTDC_OFS_DFILT_CFG1,
        `PTDC_OFS_DFILT_CFG2, `PTDC_OFS_DSP_CFG2, `PTDC_OFS_DSP_CFG3};
    localparam logic [15:0] RST[8] = '{`PTDC_RST_PTP_CFG, `PTDC_RST_FEF_CTL,
        `PTDC_RST_TXC_PHASE, `PTDC_RST_DSP_CFG1, `PTDC_RST_DFILT_CFG1,
        `PTDC_RST_DFILT_CFG2, `PTDC_RST_DSP_CFG2, `PTDC_RST_DSP_CFG3};
    localparam logic [15:0] MSK[8] = '{16'hFFFF, 16'hFFFF, `PTDC_WM_TXC_PHASE,
        `PTDC_WM_DSP_CFG1, `PTDC_WM_DFILT_CFG1, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    localparam logic [3:0]  PH[4] = '{4'h2, 4'h0, 4'hF, 4'h9};

    ptdc_regs dut_u (.*);

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // bus cycles: one strobe per edge, back to back allowed
    task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        rd    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [8:0] a, input logic [15:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        wr   <= 1'b0;
        exp_q.push_back(e);
    endtask : rd_reg

    task automatic idle(input int n);
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    // read data stands only in the cycle after the strobe, so compare there
    always @(posedge mclk) begin
        if (rd_d) begin
            chk("rdata", exp_q.pop_front(), rdata_q);
        end
        rd_d <= rd;
    end

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #(25 * 20000);
        bad_count++;
        final_report();
    end

    initial begin
        int         tt, rt;
        logic [3:0] pins, cur;
        {mclk, rst_b, wr, rd, tx_sfd_in, rx_sfd_in, gain_train_start, rd_d} = 8'h00;
        {interrupt_powerdown_pin_in, col_pin_in, far_end_fault_req, far_end_fault_rx} = 4'h0;
        {addr, wdata, sfd_pulse_pin_select, cable_metric, cur} = 36'h0;
        void'($urandom(32'hA7A0));
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (OFS[i]) begin
            rd_reg(OFS[i], RST[i]);
        end
        idle(1);
        chk("timer", 16'h000F, 16'(unlock_timer_q));
        chk("long_coef", 16'h0002, 16'(long_coef_q));
        chk("loop_sel", 16'h0001, 16'(loop_input_sel_q));
        $display("test reset done");
        // random contents, each word but the phase register read back at once
        repeat (4) begin
            far_end_fault_req <= 1'($urandom);
            far_end_fault_rx  <= 1'($urandom);
            cable_metric      <= 4'($urandom);
            for (int i = 0; i < 8; i++) begin
                if (i != 2) begin
                    w[i] = 16'($urandom);
                    wr_reg(OFS[i], w[i]);
                    rd_reg(OFS[i], (w[i] & MSK[i]) | (RST[i] & ~MSK[i]));
                end
            end
            idle(3);
            chk("timer", 16'(w[0][7:4]), 16'(unlock_timer_q));
            chk("fef_gen", 16'(far_end_fault_req & ~w[1][6]), 16'(far_end_fault_gen_q));
            chk("fef_det", 16'(far_end_fault_rx & ~w[1][5]), 16'(far_end_fault_det_q));
            chk("filt_dis", 16'(w[3][7]), 16'(filter_dis_q));
            chk("set1", 16'(cable_metric >= w[4][15:12]), 16'(coef_set1_act_q));
            chk("set0", 16'(cable_metric >= w[4][3:0]), 16'(coef_set0_act_q));
            chk("coef_en", 16'(w[4][10]), 16'(coef_en_q));
            chk("long_coef", 16'(w[4][7:6]), 16'(long_coef_q));
            chk("loop_sel", 16'(w[6][8]), 16'(loop_input_sel_q));
            gain_train_start <= 1'b1;
            @(posedge mclk);
            gain_train_start <= 1'b0;
            #1;
            chk("gain", 16'(w[7][3:0]), 16'(gain_index_q));
        end
        $display("test random done");
        // every error source code, pins held past the synchroniser
        for (int s = 0; s < 4; s++) begin
            wr_reg(`PTDC_OFS_PTP_CFG, {6'h2D, 2'(s), 8'hFF});
            interrupt_powerdown_pin_in <= 1'($urandom);
            col_pin_in                 <= 1'($urandom);
            idle(6);
            chk("tx_err", s == 2 ? 16'(interrupt_powerdown_pin_in) : s == 3 ?
                16'(col_pin_in) : 16'h0000, 16'(tx_err_q));
        end
        $display("test txerr done");
        // every delay count and pin choice
        for (int s = 0; s < 8; s++) begin
            wr_reg(`PTDC_OFS_PTP_CFG, {3'(s), 3'(7 - s), 10'h0FF});
            sfd_pulse_pin_select <= 3'(s);
            idle(3);
            tx_sfd_in <= 1'b1;
            rx_sfd_in <= 1'b1;
            {tt, rt, pins} = '0;
            for (int k = 1; k < 12; k++) begin
                @(posedge mclk);
                tx_sfd_in <= 1'b0;
                rx_sfd_in <= 1'b0;
                #1;
                if (tx_sfd_dly_q && tt == 0) begin
                    tt = k;
                    pins = {first_led_pin_sfd_q, crs_pin_sfd_q, col_pin_sfd_q,
                        interrupt_powerdown_pin_sfd_q};
                end
                if (rx_sfd_dly_q && rt == 0) begin
                    rt = k;
                end
            end
            chk("tx_dly", 16'(2 + (s * 8 + 24) / 25), 16'(tt));
            chk("rx_dly", 16'(2 + ((7 - s) * 8 + 24) / 25), 16'(rt));
            chk("pins", (s >= 3 && s <= 6) ? 16'(4'h8 >> (s - 3)) : 16'h0000, 16'(pins));
        end
        $display("test sfd done");
        // read-only bits, an unmapped place, then phase walks both ways
        wr_reg(`PTDC_OFS_TXC_PHASE, 16'hFFE0);
        rd_reg(`PTDC_OFS_TXC_PHASE, 16'h0000);
        wr_reg(9'h0AA, 16'hFFFF);
        rd_reg(9'h0AA, 16'h0000);
        foreach (PH[j]) begin
            wr_reg(`PTDC_OFS_TXC_PHASE, {11'h000, 1'b1, PH[j]});
            rd_reg(`PTDC_OFS_TXC_PHASE, {11'h000, 1'b1, cur});
            idle(0);
            {tt, rt} = '0;
            do begin
                @(posedge mclk);
                #1;
                tt += int'(txc_step_q);
                rt++;
            end while ((txc_phase_busy || rt < 3) && rt < 150);
            chk("steps", 16'(PH[j] > cur ? PH[j] - cur : cur - PH[j]), 16'(tt));
            chk("late", 16'(PH[j] > cur), 16'(txc_step_late_q));
            chk("busy", 16'h0000, 16'(txc_phase_busy));
            rd_reg(`PTDC_OFS_TXC_PHASE, {12'h000, PH[j]});
            cur = PH[j];
        end
        idle(2);
        $display("test phase done");
        final_report();
    end
endmodule : test_ptdc_regs

`default_nettype wire
